// File: design/cpml_port_mode.sv
// Purpose: Per-pin mode logic, pin drivers and config registers of seven ports
// Assumes: Programmed configuration arrives as static inputs; Avalon-MM slave
// Notes:   Pin outputs are registered, so pins lag logic by one cycle
// Operation
// - Ports E, F, G pins in microcontroller I/O mode when control bit is 0
// - I/O mode data-out register drives output; input read through data-in
// - Ports A, B, C lack control registers; I/O mode unless programmed logic
// - Logic mode uses macrocells; output on by term or set direction
// - E, F, G output latched address on enable term or direction and control; code needs the control bit set in both cases
// - Latched address nibbles follow the selected bus type
// - Upper address lines enter logic array, optionally latched by strobe; code always takes them from the strobe latch
// - Inputs used by memory select decoder count as address inputs
// - Port F as data bus disables its general I/O functions
// - Memory map bit 7 makes port F a bidirectional host data buffer
// - Peripheral buffer tri-stated unless a peripheral select term active
// - Port E carries scan pins shared with other functions
// - Bit n of each configuration register controls pin n
// - Every configuration register holds 00h after power-up
// - Ports A, B, C, F drivers enabled by direction bit or enable term
// - Programmed modes fixed; other modes changeable by host writes
// - Mode availability limited per port as listed
// - Host reaches configuration registers by ordinary decoded bus cycles
// - Direction 1 is output, 0 input; every pin defaults to input
`timescale 1ns/1ps
`default_nettype none
module cpml_port_mode
  import cpml_pkg::*;
#(
  parameter logic [1:0] BUS_TYPE = BUS_GENERIC_MUX
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_reset_n,
  input  wire logic                              i_ce,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]                 i_avs_address,
  input  wire logic                              i_avs_read,
  input  wire logic                              i_avs_write,
  input  wire logic [31:0]                       i_avs_writedata,
  output logic      [31:0]                       o_avs_readdata,
  output logic                                   o_avs_waitrequest,
  // Programmed configuration
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]  i_prog_logic_pin,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]  i_prog_addr_in_pin,
  input  wire logic                              i_prog_data_port,
  input  wire logic                              i_scan_enable,
  // Logic array interface
  input  wire cpml_logic_t                       i_logic,
  input  wire logic                              i_peripheral_select_0,
  input  wire logic                              i_peripheral_select_1,
  input  wire logic                              i_address_latch_strobe,
  input  wire logic [15:0]                       i_host_address,
  input  wire logic [7:0]                        i_host_data_out,
  output logic      [7:0]                        o_host_data_in,
  output logic                                   o_host_data_oe,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]  o_array_input,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]  o_address_input,
  // Pins
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]  i_pin,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]  o_pin,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]  o_pin_oe,
  output logic      [PORT_W-1:0]                 o_open_drain_e
);
  if (BUS_TYPE > BUS_NON_MUX) begin : g_bad_bus
    $error("cpml_port_mode bus type out of range");
  end

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] port_mask(input int p);
    return (p == PORT_D) ? PORT_D_MASK : 8'hff;
  endfunction

  function automatic logic [7:0] addr_byte(input int p, input logic [15:0] a);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = a[3:0];
    hi = a[7:4];
    case (BUS_TYPE)
      BUS_XA_MUX: begin
        lo = (p == PORT_G) ? a[11:8] : 4'h0;
        hi = (p == PORT_G) ? a[15:12] : a[7:4];
      end
      BUS_PAGE_MUX: begin
        lo = (p == PORT_G) ? a[11:8] : 4'h0;
        hi = (p == PORT_G) ? a[7:4] : 4'h0;
      end
      BUS_NON_MUX: begin
        lo = (p == PORT_G) ? a[3:0] : 4'h0;
        hi = (p == PORT_G) ? a[7:4] : 4'h0;
      end
      default: begin
        lo = a[3:0];
        hi = a[7:4];
      end
    endcase
    return {hi, lo};
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchroniser, three stages
  // ---------------------------------------------------------------------------
  logic [NUM_PORTS-1:0][PORT_W-1:0] sync_1;
  logic [NUM_PORTS-1:0][PORT_W-1:0] sync_2;
  logic [NUM_PORTS-1:0][PORT_W-1:0] sync_3;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      sync_1 <= '0;
      sync_2 <= '0;
      sync_3 <= '0;
      pin_in <= '0;
    end else if (i_ce) begin
      sync_1 <= i_pin;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int b = 0; b < PORT_W; b++) begin
          if (sync_2[p][b] == sync_3[p][b]) begin
            pin_in[p][b] <= sync_2[p][b];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  cpml_req_t req;
  logic [1:0] rd_pending;
  logic      wr_dout;
  logic      wr_dir;
  logic      wr_ctrl;
  logic      wr_drive;
  logic [7:0] memory_map_control;
  logic [7:0] dout_rd;
  logic [7:0] dir_rd;
  logic [7:0] ctrl_rd;
  logic [7:0] drive_rd;
  logic [NUM_PORTS-1:0][7:0] data_out_reg;
  logic [NUM_PORTS-1:0][7:0] dir_reg;
  logic [NUM_PORTS-1:0][7:0] ctrl_all;
  logic [NUM_PORTS-1:0][7:0] drive_reg;
  logic [NUM_PORTS-1:0][7:0] enable_out;
  logic [5:0] kind;
  logic [2:0] sel;

  assign req.address   = i_avs_address;
  assign req.read      = i_avs_read;
  assign req.write     = i_avs_write;
  assign req.writedata = i_avs_writedata[7:0];
  assign kind          = {req.address[5:3], 3'h0};
  assign sel           = req.address[2:0];

  assign wr_dout  = req.write && !o_avs_waitrequest && (kind == KIND_DATA_OUT);
  assign wr_dir   = req.write && !o_avs_waitrequest && (kind == KIND_DIR);
  assign wr_ctrl  = req.write && !o_avs_waitrequest && (kind == KIND_CTRL)
                    && (sel >= 3'(PORT_E));
  assign wr_drive = req.write && !o_avs_waitrequest && (kind == KIND_DRIVE);

  cpml_reg_bank u_dout (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_we (wr_dout), .i_waddr (sel), .i_wdata (req.writedata),
    .i_raddr (sel), .o_rdata (dout_rd), .o_all (data_out_reg)
  );
  cpml_reg_bank u_dir (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_we (wr_dir), .i_waddr (sel), .i_wdata (req.writedata),
    .i_raddr (sel), .o_rdata (dir_rd), .o_all (dir_reg)
  );
  cpml_reg_bank u_ctrl (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_we (wr_ctrl), .i_waddr (sel), .i_wdata (req.writedata),
    .i_raddr (sel), .o_rdata (ctrl_rd), .o_all (ctrl_all)
  );
  cpml_reg_bank u_drive (
    .i_sys_clk (i_sys_clk), .i_reset_n (i_reset_n), .i_ce (i_ce),
    .i_we (wr_drive), .i_waddr (sel), .i_wdata (req.writedata),
    .i_raddr (sel), .o_rdata (drive_rd), .o_all (drive_reg)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      memory_map_control <= 8'h00;
    end else if (i_ce && req.write && !o_avs_waitrequest && req.address == REG_MEM_MAP) begin
      memory_map_control <= req.writedata;
    end
  end

  // Reads wait for bank register, then read data register
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rd_pending <= 2'h0;
    end else if (i_ce) begin
      rd_pending <= (req.read && rd_pending != 2'(RD_LATENCY)) ? rd_pending + 2'h1 : 2'h0;
    end
  end

  // Idle high, so a flop can hold off the first cycle of any access
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_ce) begin
      o_avs_waitrequest <= !((req.write && o_avs_waitrequest) || (req.read && rd_pending == 2'(RD_LATENCY - 1)));
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (kind == KIND_DATA_IN && int'(sel) < NUM_PORTS) begin
      rd_byte = pin_in[sel] & port_mask(int'(sel));
    end else if (kind == KIND_DATA_OUT) begin
      rd_byte = dout_rd & port_mask(int'(sel));
    end else if (kind == KIND_DIR) begin
      rd_byte = dir_rd & port_mask(int'(sel));
    end else if (kind == KIND_CTRL && sel >= 3'(PORT_E)) begin
      rd_byte = ctrl_rd;
    end else if (kind == KIND_DRIVE) begin
      rd_byte = drive_rd & port_mask(int'(sel));
    end else if (kind == KIND_ENABLE && int'(sel) < NUM_PORTS) begin
      rd_byte = enable_out[sel];
    end else if (req.address == REG_MEM_MAP) begin
      rd_byte = memory_map_control;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce && req.read && rd_pending == 2'(RD_LATENCY - 1)) begin
      o_avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------------------------------------
  // Per-pin mode and driver logic
  // ---------------------------------------------------------------------------
  logic [NUM_PORTS-1:0][7:0] next_pin;
  logic [NUM_PORTS-1:0][7:0] next_oe;
  logic                      pio_mode;
  logic                      pio_active;
  logic                      data_port;

  assign pio_mode   = memory_map_control[MEM_MAP_PIO_BIT] && !i_prog_data_port;
  assign pio_active = pio_mode && (i_peripheral_select_0 || i_peripheral_select_1);
  assign data_port  = i_prog_data_port;

  always_comb begin
    next_pin   = '0;
    next_oe    = '0;
    enable_out = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < PORT_W; b++) begin
        logic lg;
        logic term;
        logic ctl;
        logic aout;
        logic [7:0] abyte;
        lg   = i_prog_logic_pin[p][b] && (p != PORT_E) && (p != PORT_G);
        term = i_logic.oe_term[p][b] && (p != PORT_D);
        ctl  = (p >= PORT_E) ? ctrl_all[p][b] : 1'b0;
        aout = (p >= PORT_E) && (term || (dir_reg[p][b] && ctl));
        abyte = addr_byte(p, i_host_address);
        if (p != PORT_E && p != PORT_G) begin
          enable_out[p][b] = (dir_reg[p][b] || term) && (p != PORT_D || b < PORT_D_W);
        end
        if (p == PORT_D && b >= PORT_D_W) begin
          next_oe[p][b] = 1'b0;
        end else if (p == PORT_E && i_scan_enable) begin
          next_oe[p][b] = 1'b0;
        end else if (p == PORT_F && (data_port || pio_mode)) begin
          next_pin[p][b] = i_host_data_out[b];
          next_oe[p][b]  = pio_active && !data_port ? 1'b1 : 1'b0;
        end else if (ctl && aout) begin
          next_pin[p][b] = abyte[b];
          next_oe[p][b]  = 1'b1;
        end else if (lg) begin
          next_pin[p][b] = i_logic.value[p][b];
          next_oe[p][b]  = dir_reg[p][b] || term;
        end else begin
          next_pin[p][b] = data_out_reg[p][b];
          next_oe[p][b]  = dir_reg[p][b] || term;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_pin    <= '0;
      o_pin_oe <= '0;
    end else if (i_ce) begin
      o_pin    <= next_pin;
      o_pin_oe <= next_oe;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_open_drain_e <= 8'h00;
    end else if (i_ce) begin
      o_open_drain_e <= drive_reg[PORT_E];
    end
  end

  // ---------------------------------------------------------------------------
  // Inputs to logic array and host data path
  // ---------------------------------------------------------------------------
  logic [NUM_PORTS-1:0][7:0] addr_latch;
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      addr_latch      <= '0;
      o_array_input   <= '0;
      o_address_input <= '0;
    end else if (i_ce) begin
      if (i_address_latch_strobe) begin
        addr_latch <= pin_in;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        o_array_input[p] <= pin_in[p] & i_prog_logic_pin[p] & port_mask(p);
        // decoder inputs taken as address inputs; E and G excluded
        o_address_input[p] <= ((p == PORT_E || p == PORT_G) ? 8'h00 :
                               (addr_latch[p] & i_prog_addr_in_pin[p] & port_mask(p)));
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_host_data_in <= 8'h00;
      o_host_data_oe <= 1'b0;
    end else if (i_ce) begin
      o_host_data_in <= pin_in[PORT_F];
      o_host_data_oe <= pio_active;
    end
  end
endmodule : cpml_port_mode
`default_nettype wire

// File: design/cpml_pkg.sv
// Purpose: Constants and carrier types for the configurable port mode logic
// Assumes: Avalon-MM word addressing, 8-bit registers in low bits of 32-bit data
// Notes:   Register offsets are word indices; byte address is four times the index
package cpml_pkg;
  // ---------------------------------------------------------------------------
  // Ports
  // ---------------------------------------------------------------------------
  localparam int NUM_PORTS   = 7;
  localparam int PORT_A      = 0;
  localparam int PORT_B      = 1;
  localparam int PORT_C      = 2;
  localparam int PORT_D      = 3;
  localparam int PORT_E      = 4;
  localparam int PORT_F      = 5;
  localparam int PORT_G      = 6;
  localparam int PORT_W      = 8;
  localparam int PORT_D_W    = 4;
  localparam logic [7:0] PORT_D_MASK = 8'h0f;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  // ---------------------------------------------------------------------------
  // Register map: index = kind * 8 + port
  // ---------------------------------------------------------------------------
  localparam logic [5:0] KIND_DATA_IN  = 6'h00;
  localparam logic [5:0] KIND_DATA_OUT = 6'h08;
  localparam logic [5:0] KIND_DIR      = 6'h10;
  localparam logic [5:0] KIND_CTRL     = 6'h18;
  localparam logic [5:0] KIND_DRIVE    = 6'h20;
  localparam logic [5:0] KIND_ENABLE   = 6'h28;
  localparam logic [5:0] REG_MEM_MAP   = 6'h30;
  localparam int         MEM_MAP_PIO_BIT = 7;
  localparam int         ADDR_W      = 6;
  localparam int         RD_LATENCY  = 2;
  // ---------------------------------------------------------------------------
  // Latched address bus type
  // ---------------------------------------------------------------------------
  localparam logic [1:0] BUS_GENERIC_MUX = 2'h0;
  localparam logic [1:0] BUS_XA_MUX      = 2'h1;
  localparam logic [1:0] BUS_PAGE_MUX    = 2'h2;
  localparam logic [1:0] BUS_NON_MUX     = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [7:0]        writedata;
  } cpml_req_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0][PORT_W-1:0] oe_term;
    logic [NUM_PORTS-1:0][PORT_W-1:0] value;
  } cpml_logic_t;
endpackage : cpml_pkg

// File: design/cpml_reg_bank.sv
// Purpose: Small register memory holding one byte per port for a register kind
// Assumes: Single write port, registered read data
// Notes:   Clears to reset value under synchronous reset
`timescale 1ns/1ps
`default_nettype none
module cpml_reg_bank
  import cpml_pkg::*;
#(
  parameter int DEPTH = NUM_PORTS
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_ce,
  input  wire logic                     i_we,
  input  wire logic [2:0]               i_waddr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic [2:0]               i_raddr,
  output logic      [7:0]               o_rdata,
  output logic      [DEPTH-1:0][7:0]    o_all
);
  if (DEPTH < 1 || DEPTH > 8) begin : g_bad_depth
    $error("cpml_reg_bank depth out of range");
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        o_all[k] <= CFG_RESET;
      end
    end else if (i_ce && i_we && (int'(i_waddr) < DEPTH)) begin
      o_all[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= (int'(i_raddr) < DEPTH) ? o_all[i_raddr] : 8'h00;
    end
  end
endmodule : cpml_reg_bank
`default_nettype wire

// File: test/cpml_port_mode_sva.sv
// Purpose: Concurrent checks on the port mode block ports
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module cpml_port_mode_sva
  import cpml_pkg::*;
(
  input wire logic                             i_sys_clk,
  input wire logic                             i_reset_n,
  input wire logic                             i_avs_read,
  input wire logic                             i_avs_write,
  input wire logic [31:0]                      o_avs_readdata,
  input wire logic                             o_avs_waitrequest,
  input wire logic                             i_prog_data_port,
  input wire logic                             i_scan_enable,
  input wire cpml_logic_t                      i_logic,
  input wire logic                             i_peripheral_select_0,
  input wire logic                             i_peripheral_select_1,
  input wire logic                             o_host_data_oe,
  input wire logic [NUM_PORTS-1:0][PORT_W-1:0] o_pin_oe
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  property p_wr_one; i_avs_write && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_wr_one: assert property (p_wr_one) else $error("write wait too long");
  property p_rd_first; i_avs_read && !$past(i_avs_read) |-> o_avs_waitrequest; endproperty
  a_rd_first: assert property (p_rd_first) else $error("read not held");
  property p_rd_one;
    $rose(i_avs_read) |-> o_avs_waitrequest ##1 o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read wait too long");
  property p_rd_upper; o_avs_readdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  // Own disable, so the reset itself is checked
  property p_reset_oe;
    @(posedge i_sys_clk) disable iff (1'b0) !i_reset_n |=> (o_pin_oe == '0) && !o_host_data_oe;
  endproperty
  a_reset_oe: assert property (p_reset_oe) else $error("drivers on after reset");
  property p_dport; i_prog_data_port && $past(i_prog_data_port) |-> o_pin_oe[PORT_F] == 8'h00; endproperty
  a_dport: assert property (p_dport) else $error("port f driven as data port");
  property p_scan; i_scan_enable && $past(i_scan_enable) |-> o_pin_oe[PORT_E] == 8'h00; endproperty
  a_scan: assert property (p_scan) else $error("port e driven during scan");
  property p_hostoe;
    o_host_data_oe |-> $past(i_peripheral_select_0 || i_peripheral_select_1) && !$past(i_prog_data_port);
  endproperty
  a_hostoe: assert property (p_hostoe) else $error("host buffer open without select");
  property p_port_d; o_pin_oe[PORT_D][7:4] == 4'h0; endproperty
  a_port_d: assert property (p_port_d) else $error("missing port d pin driven");
  property p_oe_or;
    $past(i_reset_n) |-> ($past(i_logic.oe_term[PORT_B]) & ~o_pin_oe[PORT_B]) == 8'h00;
  endproperty
  a_oe_or: assert property (p_oe_or) else $error("enable term ignored on port b");
  c_read: cover property ($fell(o_avs_waitrequest));
  c_hostoe: cover property (o_host_data_oe);
  c_addr_out: cover property (o_pin_oe[PORT_E] == 8'hff);
endmodule // cpml_port_mode_sva
bind cpml_port_mode cpml_port_mode_sva i_sva (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_prog_data_port(i_prog_data_port),
  .i_scan_enable(i_scan_enable), .i_logic(i_logic), .i_peripheral_select_0(i_peripheral_select_0),
  .i_peripheral_select_1(i_peripheral_select_1), .o_host_data_oe(o_host_data_oe), .o_pin_oe(o_pin_oe));
`default_nettype wire

// File: test/cpml_pin_model.sv
// Purpose: Board side of the port pins
// Assumes: Outside world drives a pin only while the block does not
// Notes:   No contention modelled
`timescale 1ns/1ps
`default_nettype none
module cpml_pin_model
  import cpml_pkg::*;
(
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] i_pin_out,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] i_pin_oe,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] i_ext,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0] o_pin_level
);
  // ---------------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------------
  // Driven pins read back their own value, others the board value
  assign o_pin_level = (i_pin_out & i_pin_oe) | (i_ext & ~i_pin_oe);
endmodule // cpml_pin_model
`default_nettype wire

// File: test/cpml_port_mode_tb.sv
// Purpose: Self-checking bench for the port mode block
// Assumes: Avalon-MM master tasks, board modelled by the pin model
// Notes:   Register rows first, then reset and mode scenarios
`timescale 1ns/1ps
`default_nettype none
module cpml_port_mode_tb
  import cpml_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                             sys_clk, rst_n, ce, rd, wr, sel0, sel1, strobe, dport, scan, hoe, wreq;
  logic [5:0]                       addr;
  logic [31:0]                      wdata, rdata;
  logic [15:0]                      haddr;
  logic [7:0]                       hdout, hdin, od;
  logic [NUM_PORTS-1:0][PORT_W-1:0] prog_lp, prog_ai, ext, pin, pout, poe, ain, arr;
  cpml_logic_t                      lg;
  int                               failures, n_tests;
  // Address, write data, expected read back
  localparam logic [21:0] ROWS [9] = '{{6'h10, 8'h5a, 8'h5a}, {6'h13, 8'hff, 8'h0f}, {6'h1c, 8'h81, 8'h81},
    {6'h18, 8'h55, 8'h00}, {6'h0e, 8'h3c, 8'h3c}, {6'h24, 8'hc3, 8'hc3}, {6'h30, 8'h80, 8'h80},
    {6'h3f, 8'h77, 8'h00}, {6'h28, 8'hff, 8'h5a}};
  cpml_port_mode i_dut (.i_sys_clk(sys_clk), .i_reset_n(rst_n), .i_ce(ce), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_prog_logic_pin(prog_lp), .i_prog_addr_in_pin(prog_ai),
    .i_prog_data_port(dport), .i_scan_enable(scan), .i_logic(lg), .i_peripheral_select_0(sel0),
    .i_peripheral_select_1(sel1), .i_address_latch_strobe(strobe), .i_host_address(haddr),
    .i_host_data_out(hdout), .o_host_data_in(hdin), .o_host_data_oe(hoe), .o_array_input(arr),
    .o_address_input(ain), .i_pin(pin), .o_pin(pout), .o_pin_oe(poe), .o_open_drain_e(od));
  cpml_pin_model i_pins (.i_pin_out(pout), .i_pin_oe(poe), .i_ext(ext), .o_pin_level(pin));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until an edge with waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr  <= a;
    wdata <= {24'h000000, d};
    wr    <= w;
    rd    <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q  = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0) begin
      chk("waitrequest", 8'h00, 8'h01);
      give_verdict();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic pulse_strobe;
    @(posedge sys_clk) strobe <= 1'b1;
    @(posedge sys_clk) strobe <= 1'b0;
  endtask
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin : main
    logic [31:0] q;
    {rst_n, rd, wr, sel0, sel1, strobe, dport, scan} = '0;
    ce = 1'b1;
    {addr, wdata, haddr, hdout, prog_lp, prog_ai, ext, lg} = '0;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, ROWS[i][21:16], ROWS[i][15:8], q);
      bus(1'b0, ROWS[i][21:16], 8'h00, q);
      chk("read back", ROWS[i][7:0], q[7:0]);
    end
    chk("open drain e", 8'hc3, od);
    $display("test register rows done");
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(0);
    for (int p = 0; p < NUM_PORTS; p++) chk("oe after reset", 8'h00, poe[p]);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, ROWS[i][21:16], 8'h00, q);
      chk("reset value", 8'h00, q[7:0]);
    end
    $display("test reset done");
    bus(1'b1, 6'h10, 8'h07, q);
    bus(1'b1, 6'h08, 8'ha5, q);
    wt(2);
    chk("oe a", 8'h07, poe[PORT_A]);
    chk("pin a", 8'h05, pout[PORT_A] & poe[PORT_A]);
    // Pin seen through the synchroniser, so allow its delay
    @(posedge sys_clk) ext[PORT_D] <= 8'hfb;
    wt(8);
    bus(1'b0, 6'h03, 8'h00, q);
    chk("data in d", 8'h0b, q[7:0]);
    $display("test mcu io done");
    @(posedge sys_clk) begin
      prog_lp[PORT_B]    <= 8'hff;
      lg.value[PORT_B]   <= 8'h3c;
      lg.oe_term[PORT_B] <= 8'h0f;
    end
    bus(1'b1, 6'h11, 8'h30, q);
    wt(2);
    chk("oe b", 8'h3f, poe[PORT_B]);
    chk("pin b", 8'h3c, pout[PORT_B] & poe[PORT_B]);
    @(posedge sys_clk) lg.oe_term[PORT_B] <= 8'h00;
    bus(1'b1, 6'h11, 8'h00, q);
    wt(2);
    chk("oe b off", 8'h00, poe[PORT_B]);
    $display("test logic io done");
    // Set at run time, after booting from inside
    @(posedge sys_clk) haddr <= 16'h005a;
    pulse_strobe();
    bus(1'b1, 6'h1c, 8'hff, q);
    bus(1'b1, 6'h14, 8'hff, q);
    wt(2);
    chk("oe e", 8'hff, poe[PORT_E]);
    chk("address e", 8'h5a, pout[PORT_E]);
    @(posedge sys_clk) scan <= 1'b1;
    wt(2);
    chk("scan e", 8'h00, poe[PORT_E]);
    @(posedge sys_clk) scan <= 1'b0;
    bus(1'b1, 6'h14, 8'h00, q);
    wt(2);
    chk("control only e", 8'h00, poe[PORT_E]);
    $display("test address out done");
    bus(1'b1, 6'h30, 8'h80, q);
    @(posedge sys_clk) begin
      sel0         <= 1'b1;
      hdout        <= 8'h3c;
    end
    wt(8);
    chk("host oe", 8'h01, {7'h00, hoe});
    chk("host data", 8'h3c, hdin);
    @(posedge sys_clk) sel0 <= 1'b0;
    wt(2);
    chk("host oe idle", 8'h00, {7'h00, hoe});
    @(posedge sys_clk) sel1 <= 1'b1;
    wt(2);
    chk("host oe sel1", 8'h01, {7'h00, hoe});
    @(posedge sys_clk) dport <= 1'b1;
    bus(1'b1, 6'h15, 8'hff, q);
    wt(2);
    chk("data port host oe", 8'h00, {7'h00, hoe});
    chk("data port oe f", 8'h00, poe[PORT_F]);
    $display("test port f done");
    @(posedge sys_clk) begin
      prog_ai[PORT_C] <= 8'hff;
      prog_lp[PORT_C] <= 8'hff;
      ext[PORT_C]     <= 8'h99;
    end
    wt(8);
    pulse_strobe();
    wt(4);
    chk("address in c", 8'h99, ain[PORT_C]);
    chk("array input c", 8'h99, arr[PORT_C]);
    $display("test address in done");
    give_verdict();
  end
endmodule // cpml_port_mode_tb
`default_nettype wire
